// >>> psa_core_state.sv
// processor-state unit: soft reset, ordering field, implicit space id, counter masking
//
// Overview of operation
// RULE_01: soft reset below hyper mode is illegal opcode
// RULE_02: soft reset in hyper mode traps, only there
// RULE_03: ordering field reads zero, writes ignored
// RULE_04: ordering field never exceeds written value
// RULE_05: fetches use kernel id while level nonzero
// RULE_06: data accesses pick kernel id by endian flag
// RULE_07: masked link writes keep low 32 bits
// RULE_08: masked trap saves keep low 32 bits
// RULE_09: unmasked values pass full 64 bits
`timescale 1ns/100ps
`default_nettype none
module psa_core_state #(
    parameter logic [7:0] KERNEL_ID    = 8'h01,
    parameter logic [7:0] KERNEL_LE_ID = 8'h02,
    parameter logic [7:0] PRIMARY_ID   = 8'h00
) (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // instruction stream
    input  wire psa_pkg::psa_mode_t        priv_mode,
    input  wire psa_pkg::psa_exec_t        exec,
    // results
    output logic                           illegal_opcode,
    output logic                           soft_reset_trap,
    output psa_pkg::psa_link_t             link,
    output logic [7:0]                     fetch_space_id,
    output logic [7:0]                     ldst_space_id,
    // trap save readback
    input  wire logic [psa_pkg::LVL_W-1:0] save_rd_level,
    output psa_pkg::psa_save_t             save_rd,
    // interrupt
    output logic                           irq
);
    typedef struct packed {
        logic                      aw_got;
        logic [7:0]                aw_addr;
        logic                      w_got;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
        logic                      addr_mask_flag;
        logic                      trap_little_endian_flag;
        logic [1:0]                mem_order_field;
        logic [psa_pkg::LVL_W-1:0] trap_level;
        logic [psa_pkg::EV_W-1:0]  status;
        logic [psa_pkg::EV_W-1:0]  mask;
        logic                      illegal_opcode;
        logic                      soft_reset_trap;
        logic [7:0]                fetch_id;
        logic [7:0]                ldst_id;
    } psa_state_t;

    psa_state_t                st;
    psa_state_t                next_st;
    logic                      wr_fire;
    logic                      sreset_ok;
    logic [psa_pkg::EV_W-1:0]  ev;
    logic [psa_pkg::LVL_W-1:0] trap_lvl_new;
    psa_pkg::psa_save_t        save_wdata;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] read_reg(input psa_state_t s, input logic [7:0] a);
        read_reg = 32'h0000_0000;
        case (a)
            psa_pkg::REG_CTRL: begin
                // ordering field always reads as zero: only strong order exists
                read_reg[psa_pkg::CTRL_MASK_BIT] = s.addr_mask_flag;
                read_reg[psa_pkg::CTRL_LE_BIT]   = s.trap_little_endian_flag;
                read_reg[psa_pkg::CTRL_ORD_HI:psa_pkg::CTRL_ORD_LO] = s.mem_order_field; // [RULE_03]
            end
            psa_pkg::REG_LEVEL:  read_reg[psa_pkg::LVL_W-1:0] = s.trap_level;
            psa_pkg::REG_STATUS: read_reg[psa_pkg::EV_W-1:0]  = s.status;
            psa_pkg::REG_MASK:   read_reg[psa_pkg::EV_W-1:0]  = s.mask;
            default:             read_reg = 32'h0000_0000;
        endcase
    endfunction : read_reg

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == psa_pkg::REG_CTRL) || (a == psa_pkg::REG_LEVEL) ||
                 (a == psa_pkg::REG_STATUS) || (a == psa_pkg::REG_MASK);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    assign wr_fire   = st.aw_got && st.w_got && !st.bvalid;
    assign sreset_ok = (priv_mode == psa_pkg::PSA_HYPER);
    assign trap_lvl_new = (st.trap_level < psa_pkg::LVL_W'(psa_pkg::MAX_LVL)) ?
                          st.trap_level + psa_pkg::LVL_W'(1) : st.trap_level;

    always_comb begin
        ev = '0;
        ev[psa_pkg::EV_ILLEGAL] = exec.sreset_valid && !sreset_ok;
        ev[psa_pkg::EV_SRESET]  = exec.sreset_valid && sreset_ok;
        ev[psa_pkg::EV_TRAP]    = exec.trap_valid;
    end

    // trap save values are masked against the flag in force when the trap is taken
    always_comb begin
        save_wdata.saved_cnt      = psa_pkg::mask_counter(exec.prog_cnt, st.addr_mask_flag); // [RULE_08] [RULE_09]
        save_wdata.saved_next_cnt = psa_pkg::mask_counter(exec.next_cnt, st.addr_mask_flag); // [RULE_08] [RULE_09]
    end

    always_comb begin
        next_st = st;
        // write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = mapped(st.aw_addr) ? psa_pkg::RESP_OKAY : psa_pkg::RESP_SLVERR;
            if (st.wstrb[0]) begin
                case (st.aw_addr)
                    psa_pkg::REG_CTRL: begin
                        next_st.addr_mask_flag          = st.wdata[psa_pkg::CTRL_MASK_BIT];
                        next_st.trap_little_endian_flag = st.wdata[psa_pkg::CTRL_LE_BIT];
                        // ordering write dropped, so field never exceeds what was written
                        next_st.mem_order_field = psa_pkg::ORDER_RST; // [RULE_03] [RULE_04]
                    end
                    psa_pkg::REG_LEVEL: next_st.trap_level = st.wdata[psa_pkg::LVL_W-1:0];
                    psa_pkg::REG_STATUS: next_st.status = st.status & ~st.wdata[psa_pkg::EV_W-1:0];
                    psa_pkg::REG_MASK:   next_st.mask   = st.wdata[psa_pkg::EV_W-1:0];
                    default: next_st.mask = st.mask;
                endcase
            end
        end
        // read channel
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_reg(st, s_axi_araddr);
            next_st.rresp  = mapped(s_axi_araddr) ? psa_pkg::RESP_OKAY : psa_pkg::RESP_SLVERR;
        end
        // trap entry overrides a software level write in the same cycle
        if (exec.trap_valid) begin
            next_st.trap_level = trap_lvl_new;
        end
        // hardware set wins over a write-one clear
        next_st.status = next_st.status | ev;
        next_st.illegal_opcode  = ev[psa_pkg::EV_ILLEGAL]; // [RULE_01]
        next_st.soft_reset_trap = ev[psa_pkg::EV_SRESET]; // [RULE_02]
        if (next_st.trap_level != '0) begin
            next_st.fetch_id = KERNEL_ID; // [RULE_05]
            next_st.ldst_id  = next_st.trap_little_endian_flag ? KERNEL_LE_ID : KERNEL_ID; // [RULE_06]
        end else begin
            next_st.fetch_id = PRIMARY_ID;
            next_st.ldst_id  = PRIMARY_ID;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= '0;
            st.fetch_id <= PRIMARY_ID;
            st.ldst_id  <= PRIMARY_ID;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    psa_link_mask u_link (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .req_valid      (exec.link_valid),
        .req_cnt        (exec.prog_cnt),
        .addr_mask_flag (st.addr_mask_flag),
        .link           (link)
    );

    psa_save_mem u_save (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (exec.trap_valid),
        .waddr   (trap_lvl_new),
        .wdata   (save_wdata),
        .raddr   (save_rd_level),
        .rdata   (save_rd)
    );

    assign s_axi_awready   = !st.aw_got && !st.bvalid;
    assign s_axi_wready    = !st.w_got && !st.bvalid;
    assign s_axi_bvalid    = st.bvalid;
    assign s_axi_bresp     = st.bresp;
    assign s_axi_arready   = !st.rvalid;
    assign s_axi_rvalid    = st.rvalid;
    assign s_axi_rdata     = st.rdata;
    assign s_axi_rresp     = st.rresp;
    assign illegal_opcode  = st.illegal_opcode;
    assign soft_reset_trap = st.soft_reset_trap;
    assign fetch_space_id  = st.fetch_id;
    assign ldst_space_id   = st.ldst_id;
    assign irq             = |(st.status & st.mask);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sreset_illegal;
        exec.sreset_valid && !sreset_ok |=> illegal_opcode && !soft_reset_trap;
    endproperty
    a_sreset_illegal: assert property (p_sreset_illegal) // [RULE_01]
        else $error("soft reset outside hyper mode not illegal");

    property p_sreset_trap;
        exec.sreset_valid && sreset_ok |=> soft_reset_trap && !illegal_opcode;
    endproperty
    a_sreset_trap: assert property (p_sreset_trap) // [RULE_02]
        else $error("soft reset in hyper mode did not trap");

    property p_sreset_only_hyper;
        soft_reset_trap |-> $past(exec.sreset_valid) && $past(priv_mode) == psa_pkg::PSA_HYPER;
    endproperty
    a_sreset_only_hyper: assert property (p_sreset_only_hyper) // [RULE_02]
        else $error("soft reset trap without hyper-mode cause");

    property p_order_zero;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == psa_pkg::REG_CTRL
            |=> s_axi_rvalid && s_axi_rdata[3:2] == 2'h0;
    endproperty
    a_order_zero: assert property (p_order_zero) // [RULE_03]
        else $error("ordering field read nonzero");

    property p_order_nogrow;
        wr_fire && st.aw_addr == psa_pkg::REG_CTRL
            |=> st.mem_order_field <= $past(st.wdata[3:2]);
    endproperty
    a_order_nogrow: assert property (p_order_nogrow) // [RULE_04]
        else $error("ordering field above written value");

    property p_fetch_kernel;
        st.trap_level != '0 |-> fetch_space_id == KERNEL_ID;
    endproperty
    a_fetch_kernel: assert property (p_fetch_kernel) // [RULE_05]
        else $error("fetch space id not kernel at nonzero level");

    property p_ldst_kernel;
        st.trap_level != '0 |->
            ldst_space_id == (st.trap_little_endian_flag ? KERNEL_LE_ID : KERNEL_ID);
    endproperty
    a_ldst_kernel: assert property (p_ldst_kernel) // [RULE_06]
        else $error("data space id wrong at nonzero level");

    property p_link_masked;
        exec.link_valid && st.addr_mask_flag |=>
            link.valid && link.data == {32'h0000_0000, $past(exec.prog_cnt[31:0])};
    endproperty
    a_link_masked: assert property (p_link_masked) // [RULE_07]
        else $error("masked link value wrong");

    property p_trap_masked;
        exec.trap_valid && st.addr_mask_flag |->
            save_wdata.saved_cnt == {32'h0000_0000, exec.prog_cnt[31:0]} &&
            save_wdata.saved_next_cnt == {32'h0000_0000, exec.next_cnt[31:0]};
    endproperty
    a_trap_masked: assert property (p_trap_masked) // [RULE_08]
        else $error("masked trap save wrong");

    property p_link_full;
        exec.link_valid && !st.addr_mask_flag |=> link.data == $past(exec.prog_cnt);
    endproperty
    a_link_full: assert property (p_link_full) // [RULE_09]
        else $error("unmasked link value altered");

    c_sreset_hyper: cover property (exec.sreset_valid && sreset_ok);
    c_sreset_low:   cover property (exec.sreset_valid && priv_mode == psa_pkg::PSA_NONPRIV);
    c_trap_masked:  cover property (exec.trap_valid && st.addr_mask_flag);
    c_irq:          cover property (irq ##1 !irq);
endmodule : psa_core_state
`default_nettype wire

// >>> psa_core_state_tb.sv
// self-checking bench for the processor-state unit over its register bus and exec port
`timescale 1ns/100ps
`default_nettype none
module psa_core_state_tb;

    localparam logic [7:0] KID  = 8'h01;
    localparam logic [7:0] KLE  = 8'h02;
    localparam logic [7:0] PRIM = 8'h00;

    logic                      aclk;
    logic                      aresetn;
    logic [7:0]                awaddr;
    logic                      awvalid;
    logic                      awready;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      wvalid;
    logic                      wready;
    logic [1:0]                bresp;
    logic                      bvalid;
    logic                      bready;
    logic [7:0]                araddr;
    logic                      arvalid;
    logic                      arready;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic                      rvalid;
    logic                      rready;
    psa_pkg::psa_mode_t        mode;
    psa_pkg::psa_exec_t        exec;
    logic                      illegal_opcode;
    logic                      soft_reset_trap;
    psa_pkg::psa_link_t        link;
    logic [7:0]                fetch_id;
    logic [7:0]                ldst_id;
    logic [psa_pkg::LVL_W-1:0] rd_level;
    psa_pkg::psa_save_t        save_rd;
    logic                      irq;
    int                        n_errors;
    int                        checks_done;

    psa_core_state #(.KERNEL_ID(KID), .KERNEL_LE_ID(KLE), .PRIMARY_ID(PRIM)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .priv_mode(mode), .exec(exec), .illegal_opcode(illegal_opcode),
        .soft_reset_trap(soft_reset_trap), .link(link), .fetch_space_id(fetch_id),
        .ldst_space_id(ldst_id), .save_rd_level(rd_level), .save_rd(save_rd), .irq(irq)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : check

    task automatic hang(input string what);
        $display("unexpected %s: expected answer seen none", what);
        n_errors++;
        report_and_stop();
    endtask : hang

    // both channels offered together, each released at its own handshake edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                check("write response", {62'h0, er}, {62'h0, bresp});
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("write response");
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                check("read data", {32'h0, ed}, {32'h0, rdata});
                check("read response", {62'h0, er}, {62'h0, rresp});
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("read data");
    endtask : axi_read

    // one-cycle exec pulse; returns once its registered results have settled
    task automatic do_exec(input logic s, input logic l, input logic t,
                           input logic [63:0] cur_cnt, input logic [63:0] nxt_cnt);
        @(posedge aclk);
        exec.sreset_valid <= s;
        exec.link_valid   <= l;
        exec.trap_valid   <= t;
        exec.prog_cnt     <= cur_cnt;
        exec.next_cnt     <= nxt_cnt;
        @(posedge aclk);
        exec.sreset_valid <= 1'b0;
        exec.link_valid   <= 1'b0;
        exec.trap_valid   <= 1'b0;
        #1;
    endtask : do_exec

    task automatic check_save(input logic [2:0] lvl, input logic [63:0] cur_cnt,
                              input logic [63:0] nxt_cnt);
        @(posedge aclk);
        rd_level <= lvl;
        repeat (2) @(posedge aclk);
        #1;
        check("saved counter", cur_cnt, save_rd.saved_cnt);
        check("saved next counter", nxt_cnt, save_rd.saved_next_cnt);
    endtask : check_save

    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        psa_pkg::psa_mode_t modes [3];
        logic [63:0] cur_cnt;
        logic [63:0] nxt_cnt;
        modes = '{psa_pkg::PSA_NONPRIV, psa_pkg::PSA_PRIV, psa_pkg::PSA_HYPER};
        cur_cnt = 64'hA5C3_0F1E_8765_4320;
        nxt_cnt = 64'hA5C3_0F1E_8765_4324;
        n_errors = 0;
        checks_done = 0;
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        mode = psa_pkg::PSA_NONPRIV;
        exec = '0;
        rd_level = 3'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;

        // reset values and bus refusal of an unmapped word
        for (int i = 0; i < 4; i++) axi_read(8'(4 * i), 32'h0, psa_pkg::RESP_OKAY);
        check("fetch id", {56'h0, PRIM}, {56'h0, fetch_id});
        axi_read(8'h10, 32'h0, psa_pkg::RESP_SLVERR);
        axi_write(8'h10, 32'hFFFF_FFFF, psa_pkg::RESP_SLVERR);
        // low byte lane off: answered, but nothing stored
        @(posedge aclk);
        wstrb <= 4'h0;
        axi_write(psa_pkg::REG_MASK, 32'h0000_0007, psa_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        axi_read(psa_pkg::REG_MASK, 32'h0, psa_pkg::RESP_OKAY);
        $display("test reset_and_map done");

        // ordering field stays zero whatever is written
        axi_write(psa_pkg::REG_CTRL, 32'h0000_000C, psa_pkg::RESP_OKAY);
        axi_read(psa_pkg::REG_CTRL, 32'h0, psa_pkg::RESP_OKAY);
        axi_write(psa_pkg::REG_CTRL, 32'h0000_0008, psa_pkg::RESP_OKAY);
        axi_read(psa_pkg::REG_CTRL, 32'h0, psa_pkg::RESP_OKAY);
        $display("test order_field done");

        // soft reset in every mode, unmasked illegal event drives irq
        axi_write(psa_pkg::REG_MASK, 32'h0000_0001, psa_pkg::RESP_OKAY);
        foreach (modes[i]) begin
            @(posedge aclk);
            mode <= modes[i];
            do_exec(1'b1, 1'b0, 1'b0, cur_cnt, nxt_cnt);
            check("illegal opcode", {63'h0, modes[i] != psa_pkg::PSA_HYPER},
                  {63'h0, illegal_opcode});
            check("soft reset trap", {63'h0, modes[i] == psa_pkg::PSA_HYPER},
                  {63'h0, soft_reset_trap});
        end
        check("irq raised", 64'h1, {63'h0, irq});
        axi_read(psa_pkg::REG_STATUS, 32'h0000_0003, psa_pkg::RESP_OKAY);
        axi_write(psa_pkg::REG_STATUS, 32'h0000_0003, psa_pkg::RESP_OKAY);
        axi_read(psa_pkg::REG_STATUS, 32'h0, psa_pkg::RESP_OKAY);
        #1;
        check("irq cleared", 64'h0, {63'h0, irq});
        $display("test soft_reset done");

        // trap unmasked: full counters saved, kernel ids selected
        do_exec(1'b0, 1'b0, 1'b1, cur_cnt, nxt_cnt);
        settle();
        check("fetch id", {56'h0, KID}, {56'h0, fetch_id});
        check("data id", {56'h0, KID}, {56'h0, ldst_id});
        check_save(3'h1, cur_cnt, nxt_cnt);
        // little-endian flag and mask flag on, then a second trap
        axi_write(psa_pkg::REG_CTRL, 32'h0000_0003, psa_pkg::RESP_OKAY);
        settle();
        check("data id", {56'h0, KLE}, {56'h0, ldst_id});
        check("fetch id", {56'h0, KID}, {56'h0, fetch_id});
        do_exec(1'b0, 1'b0, 1'b1, cur_cnt, nxt_cnt);
        check_save(3'h2, {32'h0, cur_cnt[31:0]}, {32'h0, nxt_cnt[31:0]});
        check_save(3'h1, cur_cnt, nxt_cnt);
        axi_read(psa_pkg::REG_LEVEL, 32'h0000_0002, psa_pkg::RESP_OKAY);
        $display("test trap_save done");

        // link writes, masked then unmasked
        do_exec(1'b0, 1'b1, 1'b0, cur_cnt, nxt_cnt);
        check("link valid", 64'h1, {63'h0, link.valid});
        check("link data", {32'h0, cur_cnt[31:0]}, link.data);
        axi_write(psa_pkg::REG_CTRL, 32'h0000_0000, psa_pkg::RESP_OKAY);
        do_exec(1'b0, 1'b1, 1'b0, nxt_cnt, cur_cnt);
        check("link data", nxt_cnt, link.data);
        settle();
        check("link pulse", 64'h0, {63'h0, link.valid});
        $display("test link_mask done");

        // back to level zero: primary id for both
        axi_write(psa_pkg::REG_LEVEL, 32'h0, psa_pkg::RESP_OKAY);
        settle();
        check("fetch id", {56'h0, PRIM}, {56'h0, fetch_id});
        check("data id", {56'h0, PRIM}, {56'h0, ldst_id});
        $display("test level_zero done");
        report_and_stop();
    end

endmodule : psa_core_state_tb
`default_nettype wire

// >>> psa_link_mask.sv
// registered link-value path with optional 32-bit address masking
`timescale 1ns/100ps
`default_nettype none
module psa_link_mask (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // request
    input  wire logic                     req_valid,
    input  wire logic [psa_pkg::CNT_W-1:0] req_cnt,
    input  wire logic                     addr_mask_flag,
    // result
    output var  psa_pkg::psa_link_t       link
);
    psa_pkg::psa_link_t st;
    psa_pkg::psa_link_t next_st;

    always_comb begin
        next_st       = st;
        next_st.valid = req_valid;
        if (req_valid) begin
            next_st.data = psa_pkg::mask_counter(req_cnt, addr_mask_flag); // [RULE_07] [RULE_09]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link = st;
endmodule : psa_link_mask
`default_nettype wire

// >>> psa_pkg.sv
// shared constants, types and helpers for the processor-state block
package psa_pkg;

    localparam int CNT_W    = 64;
    localparam int LVL_W    = 3;
    localparam int ID_W     = 8;
    localparam int ADDR_W   = 8;
    localparam int MAX_LVL  = 6;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_LEVEL  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK   = 8'h0C;

    // control register fields
    localparam int CTRL_MASK_BIT = 0;
    localparam int CTRL_LE_BIT   = 1;
    localparam int CTRL_ORD_LO   = 2;
    localparam int CTRL_ORD_HI   = 3;

    // status / mask fields
    localparam int EV_W       = 3;
    localparam int EV_ILLEGAL = 0;
    localparam int EV_SRESET  = 1;
    localparam int EV_TRAP    = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [LVL_W-1:0] LEVEL_RST = 3'h0;
    localparam logic [1:0]       ORDER_RST = 2'h0;

    typedef enum logic [1:0] {
        PSA_NONPRIV = 2'b00,
        PSA_PRIV    = 2'b01,
        PSA_HYPER   = 2'b11
    } psa_mode_t;

    typedef struct packed {
        logic             sreset_valid;
        logic             link_valid;
        logic             trap_valid;
        logic [CNT_W-1:0] prog_cnt;
        logic [CNT_W-1:0] next_cnt;
    } psa_exec_t;

    typedef struct packed {
        logic             valid;
        logic [CNT_W-1:0] data;
    } psa_link_t;

    typedef struct packed {
        logic [CNT_W-1:0] saved_cnt;
        logic [CNT_W-1:0] saved_next_cnt;
    } psa_save_t;

    function automatic logic [CNT_W-1:0] mask_counter(
        input logic [CNT_W-1:0] v,
        input logic             m
    );
        mask_counter = m ? {32'h0000_0000, v[31:0]} : v;
    endfunction : mask_counter

endpackage : psa_pkg

// >>> psa_save_mem.sv
// per-level trap save storage, registered read port
`timescale 1ns/100ps
`default_nettype none
module psa_save_mem #(
    parameter int LEVELS = psa_pkg::MAX_LVL + 1
) (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // write port
    input  wire logic                      we,
    input  wire logic [psa_pkg::LVL_W-1:0] waddr,
    input  wire psa_pkg::psa_save_t        wdata,
    // read port
    input  wire logic [psa_pkg::LVL_W-1:0] raddr,
    output var  psa_pkg::psa_save_t        rdata
);
    psa_pkg::psa_save_t mem [LEVELS];
    psa_pkg::psa_save_t st;
    psa_pkg::psa_save_t next_st;

    // out-of-range levels read as zero
    always_comb begin
        next_st = '0;
        if (int'(raddr) < LEVELS) begin
            next_st = mem[raddr];
        end
    end

    always_ff @(posedge aclk) begin
        if (we && int'(waddr) < LEVELS) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st;
endmodule : psa_save_mem
`default_nettype wire
